// *** logic/spimsp_pkg.sv ***
package spimsp_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] SPIMSP_IDX_CONTROL = 8'hF4;
  localparam logic [7:0] SPIMSP_IDX_STATUS = 8'hF5;
  localparam logic [7:0] SPIMSP_IDX_DATA = 8'hF6;
  localparam logic [7:0] SPIMSP_IDX_PIN_CTRL = 8'hF7;

  localparam int SPIMSP_ADDR_W = 12;

  // control register fields
  localparam int SPIMSP_CTL_RATE_LO = 0;
  localparam int SPIMSP_CTL_RATE_HI = 1;
  localparam int SPIMSP_CTL_CLOCK_PHASE_BIT = 2;
  localparam int SPIMSP_CTL_CLOCK_POLARITY_BIT = 3;
  localparam int SPIMSP_CTL_MASTER = 4;
  localparam int SPIMSP_CTL_LSB_FIRST = 5;
  localparam int SPIMSP_CTL_INT_EN = 6;
  localparam int SPIMSP_CTL_ENABLE = 7;
  localparam logic [7:0] SPIMSP_CTL_RESET = 8'h00;

  // status register fields
  localparam int SPIMSP_STA_DOUBLE_SPEED = 0;
  localparam int SPIMSP_STA_MODE_FAULT = 5;
  localparam int SPIMSP_STA_WRITE_COLLISION = 6;
  localparam int SPIMSP_STA_TRANSFER_COMPLETE = 7;
  localparam logic [7:0] SPIMSP_STA_RESET = 8'h00;

  // pin control fields: driver and function enables of the four serial pins
  localparam int SPIMSP_PIN_MISO = 0;
  localparam int SPIMSP_PIN_MOSI = 1;
  localparam int SPIMSP_PIN_SCK = 2;
  localparam int SPIMSP_PIN_NSS = 3;
  localparam logic [3:0] SPIMSP_PIN_RESET = 4'h0;
  localparam logic [3:0] SPIMSP_PIN_ALL = 4'hF;

  localparam logic [7:0] SPIMSP_DATA_RESET = 8'h00;
  localparam int SPIMSP_BITS = 8;
  localparam logic [3:0] SPIMSP_LAST_EDGE = 4'hF;

  localparam logic [1:0] SPIMSP_RESP_OKAY = 2'h0;
  localparam logic [1:0] SPIMSP_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SPIMSP_SEL_NONE,
    SPIMSP_SEL_CONTROL,
    SPIMSP_SEL_STATUS,
    SPIMSP_SEL_DATA,
    SPIMSP_SEL_PIN
  } spimsp_sel_e;

endpackage : spimsp_pkg

// *** logic/spimsp_port.sv ***
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/100ps

// Contract
// - master write to data while idle loads shifter and starts shifting
// - master shifts eight bits out on MOSI while taking eight from MISO
// - last bit copies shifter into receive buffer and sets completion flag, raising the interrupt if enabled
// - data write while busy sets write collision, byte discarded, transfer unharmed
// - master SCK is clock divided by 2 to 256 via rate and double-speed
// - master emits exactly eight SCK pulses per byte, SCK idle between bytes
// - both SCK polarities and phases supported; slave software matches master
// - enabling the port automatically assigns the four serial pin roles
// - slave load only while select low and idle; while select high deferred to select
// - slave select rising mid-byte aborts transfer without completion flag
// - each slave select assertion reloads pending transmit byte into shifter
// - slave shifting runs while CPU suspended; completion interrupt wakes it
// - each finished byte sets completion flag; an interrupt is requested only while interrupt enable is set
// - select low in master mode sets fault and completion, clears master and pins
// - completion flag clears on vector taken or status read then data access
// - write collision clears by status read then data read or write
// - mode fault clears by status read then control write
// - no transmit buffer; receive path has its own read buffer
// - reset forces control register to zero, port disabled
// - data order bit selects LSB or MSB first both directions
module spimsp_port
  import spimsp_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [SPIMSP_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // axi4-lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read address
  input wire logic [SPIMSP_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // axi4-lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // cpu interrupt
  output logic irq,
  input wire logic irq_ack,
  // serial clock pin
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_n,
  // master-out slave-in pin
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe_n,
  // master-in slave-out pin
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe_n,
  // slave select pin, input only
  input wire logic nss_n_in
);

  function automatic spimsp_sel_e decode(input logic [SPIMSP_ADDR_W-1:0] addr);
    logic [SPIMSP_ADDR_W-1:0] ctl;
    ctl = {2'h0, SPIMSP_IDX_CONTROL, 2'h0};
    if (addr == ctl) return SPIMSP_SEL_CONTROL;
    if (addr == {2'h0, SPIMSP_IDX_STATUS, 2'h0}) return SPIMSP_SEL_STATUS;
    if (addr == {2'h0, SPIMSP_IDX_DATA, 2'h0}) return SPIMSP_SEL_DATA;
    if (addr == {2'h0, SPIMSP_IDX_PIN_CTRL, 2'h0}) return SPIMSP_SEL_PIN;
    return SPIMSP_SEL_NONE;
  endfunction : decode

  // data order
  // bit that goes on the wire next
  function automatic logic first_bit(input logic [7:0] b, input logic lsb);
    return lsb ? b[0] : b[7];
  endfunction : first_bit

  // shift one place, new bit enters at the far end
  function automatic logic [7:0] shift_in(input logic [7:0] b, input logic d, input logic lsb);
    return lsb ? {d, b[7:1]} : {b[6:0], d};
  endfunction : shift_in

  logic [7:0] control;
  logic double_speed;
  logic transfer_complete_flag;
  logic write_collision;
  logic mode_fault;
  logic [3:0] port_pin_control;
  logic [7:0] rx_buf;
  logic [7:0] shifter;
  logic [7:0] tx_hold;
  logic out_bit;
  logic cap_bit;
  logic busy;
  logic [3:0] edge_cnt;
  logic [7:0] div_cnt;
  logic sck_lvl;
  logic sck_prev;
  logic nss_prev;
  logic arm_tc;
  logic arm_wc;
  logic arm_mf;

  logic aw_held;
  logic w_held;
  logic [SPIMSP_ADDR_W-1:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_strb_q;

  logic wr_go;
  logic rd_go;
  spimsp_sel_e wr_sel;
  spimsp_sel_e rd_sel;
  logic wr_ctl;
  logic wr_pin;
  logic wr_data;
  logic rd_stat;
  logic data_acc;
  logic enabled;
  logic master;
  logic lsb;
  logic clock_phase_bit;
  logic clock_polarity_bit;
  logic mode_fault_ev;
  logic nss_fall;
  logic nss_low;
  logic tick;
  logic lead_ev;
  logic trail_ev;
  logic done_ev;
  logic load_now;
  logic collide;
  logic [7:0] shifted;
  logic [2:0] rate_sel;
  logic [7:0] half_last;

  assign enabled = control[SPIMSP_CTL_ENABLE];
  assign master = control[SPIMSP_CTL_MASTER];
  assign lsb = control[SPIMSP_CTL_LSB_FIRST];
  assign clock_phase_bit = control[SPIMSP_CTL_CLOCK_PHASE_BIT];
  assign clock_polarity_bit = control[SPIMSP_CTL_CLOCK_POLARITY_BIT];
  assign nss_low = !nss_n_in;

  // bus side: the access takes effect in the cycle its answer is launched
  assign wr_go = aw_held && w_held && !bvalid;
  assign rd_go = arvalid && arready;
  assign wr_sel = decode(aw_addr_q);
  assign rd_sel = decode(araddr);
  assign wr_ctl = wr_go && wr_sel == SPIMSP_SEL_CONTROL && w_strb_q;
  assign wr_pin = wr_go && wr_sel == SPIMSP_SEL_PIN && w_strb_q;
  assign wr_data = wr_go && wr_sel == SPIMSP_SEL_DATA && w_strb_q;
  assign rd_stat = rd_go && rd_sel == SPIMSP_SEL_STATUS;
  assign data_acc = (wr_go && wr_sel == SPIMSP_SEL_DATA) || (rd_go && rd_sel == SPIMSP_SEL_DATA);

  assign mode_fault_ev = enabled && master && nss_low;

  assign rate_sel = {control[SPIMSP_CTL_RATE_HI:SPIMSP_CTL_RATE_LO], !double_speed};
  assign half_last = 8'((9'h001 << rate_sel) - 9'h001);
  assign tick = busy && master && div_cnt == half_last;

  assign nss_fall = nss_prev && nss_low;

  // edge roles follow polarity and phase
  always_comb begin
    lead_ev = 1'b0;
    trail_ev = 1'b0;
    if (enabled && master) begin
      lead_ev = tick && !edge_cnt[0];
      trail_ev = tick && edge_cnt[0];
    end else if (enabled && nss_low && !nss_prev && sck_in != sck_prev) begin
      // slave edges need no cpu activity
      lead_ev = sck_in != clock_polarity_bit;
      trail_ev = sck_in == clock_polarity_bit;
    end
  end

  assign shifted = shift_in(shifter, clock_phase_bit ? (master ? miso_in : mosi_in) : cap_bit, lsb);
  assign done_ev = trail_ev && edge_cnt[3:1] == 3'(SPIMSP_BITS - 1);
  assign collide = wr_data && enabled && busy;
  assign load_now = wr_data && !busy && (master || nss_low);

  // axi write channels; address and data may come in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      awready <= 1'b0;
      aw_addr_q <= '0;
    end else if (awvalid && awready) begin
      aw_held <= 1'b1;
      awready <= 1'b0;
      aw_addr_q <= awaddr;
    end else begin
      if (wr_go) aw_held <= 1'b0;
      awready <= !aw_held && !bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      wready <= 1'b0;
      w_data_q <= SPIMSP_DATA_RESET;
      w_strb_q <= 1'b0;
    end else if (wvalid && wready) begin
      w_held <= 1'b1;
      wready <= 1'b0;
      w_data_q <= wdata[7:0];
      w_strb_q <= wstrb[0];
    end else begin
      if (wr_go) w_held <= 1'b0;
      wready <= !w_held && !bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= SPIMSP_RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp <= (wr_sel == SPIMSP_SEL_NONE) ? SPIMSP_RESP_SLVERR : SPIMSP_RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // axi read; one read in flight, answered the cycle after acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= SPIMSP_RESP_OKAY;
    end else if (rd_go) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= SPIMSP_RESP_OKAY;
      unique case (rd_sel)
        SPIMSP_SEL_CONTROL: rdata <= {24'h0, control};
        SPIMSP_SEL_STATUS: rdata <= {24'h0, transfer_complete_flag, write_collision,
                                     mode_fault, 4'h0, double_speed};
        SPIMSP_SEL_DATA: rdata <= {24'h0, rx_buf};
        SPIMSP_SEL_PIN: rdata <= {28'h0, port_pin_control};
        SPIMSP_SEL_NONE: begin
          rdata <= '0;
          rresp <= SPIMSP_RESP_SLVERR;
        end
      endcase
    end else begin
      if (rready) rvalid <= 1'b0;
      arready <= !rvalid || rready;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control <= SPIMSP_CTL_RESET;
    end else begin
      if (wr_ctl) control <= w_data_q;
      // fault drops master select; it wins over a same-cycle write
      if (mode_fault_ev) control[SPIMSP_CTL_MASTER] <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_pin_control <= SPIMSP_PIN_RESET;
    end else if (mode_fault_ev) begin
      port_pin_control <= SPIMSP_PIN_RESET;
    end else if (wr_ctl && w_data_q[SPIMSP_CTL_ENABLE] && !enabled) begin
      port_pin_control <= SPIMSP_PIN_ALL;
    end else if (wr_pin) begin
      port_pin_control <= w_data_q[3:0];
    end
  end

  // status read arms the clear; the following access performs it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arm_tc <= 1'b0;
      arm_wc <= 1'b0;
      arm_mf <= 1'b0;
    end else if (rd_stat) begin
      arm_tc <= transfer_complete_flag;
      arm_wc <= write_collision;
      arm_mf <= mode_fault;
    end else begin
      if (data_acc) arm_tc <= 1'b0;
      if (data_acc) arm_wc <= 1'b0;
      if (wr_ctl) arm_mf <= 1'b0;
    end
  end

  // status flags: a set always beats a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      double_speed <= SPIMSP_STA_RESET[SPIMSP_STA_DOUBLE_SPEED];
      transfer_complete_flag <= SPIMSP_STA_RESET[SPIMSP_STA_TRANSFER_COMPLETE];
      write_collision <= SPIMSP_STA_RESET[SPIMSP_STA_WRITE_COLLISION];
      mode_fault <= SPIMSP_STA_RESET[SPIMSP_STA_MODE_FAULT];
    end else begin
      if (wr_go && wr_sel == SPIMSP_SEL_STATUS && w_strb_q)
        double_speed <= w_data_q[SPIMSP_STA_DOUBLE_SPEED];
      if (done_ev || mode_fault_ev) transfer_complete_flag <= 1'b1;
      else if (irq_ack || (arm_tc && data_acc)) transfer_complete_flag <= 1'b0;
      if (collide) write_collision <= 1'b1;
      else if (arm_wc && data_acc) write_collision <= 1'b0;
      if (mode_fault_ev) mode_fault <= 1'b1;
      else if (arm_mf && wr_ctl) mode_fault <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !busy || tick) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_prev <= 1'b0;
      nss_prev <= 1'b1;
    end else begin
      sck_prev <= sck_in;
      nss_prev <= nss_n_in;
    end
  end

  // shift engine shared by master and slave
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shifter <= SPIMSP_DATA_RESET;
      tx_hold <= SPIMSP_DATA_RESET;
      out_bit <= 1'b0;
      cap_bit <= 1'b0;
      busy <= 1'b0;
      edge_cnt <= 4'h0;
      rx_buf <= SPIMSP_DATA_RESET;
    end else if (!enabled || mode_fault_ev || (!master && !nss_low)) begin
      // abort without completion; write is held for the next select
      busy <= 1'b0;
      edge_cnt <= 4'h0;
      if (wr_data) tx_hold <= w_data_q;
    end else if (!busy && nss_fall && !master && !load_now) begin
      shifter <= tx_hold;
      out_bit <= first_bit(tx_hold, lsb);
    end else if (load_now) begin
      // load, and start only when master; straight into the shifter
      shifter <= w_data_q;
      tx_hold <= w_data_q;
      out_bit <= first_bit(w_data_q, lsb);
      busy <= master;
      edge_cnt <= 4'h0;
    end else begin
      if (lead_ev) begin
        busy <= 1'b1;
        edge_cnt <= edge_cnt + 4'h1;
        // phase picks sample or drive on the leading edge
        if (clock_phase_bit) out_bit <= first_bit(shifter, lsb);
        else cap_bit <= master ? miso_in : mosi_in;
      end
      if (trail_ev) begin
        // one bit out, one bit in
        shifter <= shifted;
        edge_cnt <= edge_cnt + 4'h1;
        if (!clock_phase_bit) out_bit <= first_bit(shifted, lsb);
      end
      // receive buffer copy; older byte overwritten
      if (done_ev) begin
        rx_buf <= shifted;
        busy <= 1'b0;
        edge_cnt <= 4'h0;
      end
    end
  end

  // eight pulses, idle level between bytes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_lvl <= 1'b0;
    end else if (!busy || !master) begin
      sck_lvl <= clock_polarity_bit;
    end else if (tick) begin
      sck_lvl <= (edge_cnt == SPIMSP_LAST_EDGE) ? clock_polarity_bit : !sck_lvl;
    end
  end

  // pin drivers; a fault clearing pin control turns them off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_oe_n <= 1'b1;
      mosi_oe_n <= 1'b1;
      miso_oe_n <= 1'b1;
    end else begin
      sck_oe_n <= !(enabled && master && port_pin_control[SPIMSP_PIN_SCK]);
      mosi_oe_n <= !(enabled && master && port_pin_control[SPIMSP_PIN_MOSI]);
      // slave drives MISO only while selected, so shared lines stay free
      miso_oe_n <= !(enabled && !master && nss_low && port_pin_control[SPIMSP_PIN_MISO]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_out <= 1'b0;
      mosi_out <= 1'b0;
      miso_out <= 1'b0;
    end else begin
      sck_out <= sck_lvl;
      mosi_out <= out_bit;
      miso_out <= out_bit;
    end
  end

  // gated request; this same line wakes a suspended cpu
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= transfer_complete_flag && control[SPIMSP_CTL_INT_EN];
    end
  end

endmodule : spimsp_port

// *** sim/spimsp_port_properties.sv ***
`timescale 1ns/100ps
module spimsp_port_properties
  import spimsp_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  // interrupt
  input wire logic irq,
  input wire logic irq_ack,
  // pins
  input wire logic sck_oe_n,
  input wire logic mosi_oe_n,
  input wire logic miso_oe_n,
  input wire logic nss_n_in
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response late");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_write_refused: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  a_read_answer: assert property (arvalid && arready |=> rvalid && rdata[31:8] == 24'h0)
    else $error("read answer late or upper bits set");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data changed while waiting");
  a_read_refused: assert property (rvalid |-> !arready)
    else $error("read taken while data pending");
  a_one_data_driver: assert property (!(!mosi_oe_n && !miso_oe_n))
    else $error("both data pins driven");
  a_slave_sck_input: assert property (!miso_oe_n |-> sck_oe_n)
    else $error("slave drives the clock pin");
  a_fault_release: assert property (!sck_oe_n && !nss_n_in |-> ##[1:6] sck_oe_n)
    else $error("drivers kept on after select low");
  a_ack_drops_irq: assert property (irq && irq_ack |-> ##[1:3] !irq)
    else $error("interrupt stays after vector taken");
endmodule : spimsp_port_properties

bind spimsp_port spimsp_port_properties u_props (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
  .irq(irq), .irq_ack(irq_ack), .sck_oe_n(sck_oe_n), .mosi_oe_n(mosi_oe_n),
  .miso_oe_n(miso_oe_n), .nss_n_in(nss_n_in)
);

// *** sim/spimsp_slave_model.sv ***
`timescale 1ns/100ps
module spimsp_slave_model (
  // serial pins
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  // mode and data
  input wire logic clock_polarity_bit,
  input wire logic clock_phase_bit,
  input wire logic lsb_first,
  input wire logic [7:0] tx_byte,
  input wire logic load,
  output logic [7:0] rx_byte,
  output int n_edges
);
  logic [7:0] sh = 8'h00;
  logic sck_q = 1'b0;
  assign rx_byte = sh;
  // mode and order follow the master
  always @(posedge load or sck) begin
    if (sck === sck_q) begin
      sh = tx_byte;
      n_edges = 0;
      miso = lsb_first ? tx_byte[0] : tx_byte[7];
    end else begin
      sck_q = sck;
      n_edges++;
      // sample on leading edge for phase 0, trailing for phase 1
      if ((sck !== clock_polarity_bit) == !clock_phase_bit) begin
        sh = lsb_first ? {mosi, sh[7:1]} : {sh[6:0], mosi};
      end else begin
        miso = lsb_first ? sh[0] : sh[7];
      end
    end
  end
endmodule : spimsp_slave_model

// *** sim/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
  import spimsp_pkg::*;
  typedef struct packed {logic [7:0] ctl; logic dbl; logic [7:0] tx; logic [7:0] ptx;} spimsp_row_s;
  spimsp_row_s rows [8] = '{'{8'hD0, 1'b1, 8'h5A, 8'hC3}, '{8'h90, 1'b0, 8'h0F, 8'hF0},
    '{8'hB5, 1'b1, 8'h01, 8'h80}, '{8'h99, 1'b0, 8'hA6, 8'h3D}, '{8'hFE, 1'b1, 8'h2B, 8'hD4},
    '{8'h92, 1'b0, 8'hFF, 8'h00}, '{8'h9F, 1'b1, 8'h71, 8'h8E}, '{8'hBB, 1'b0, 8'hC8, 8'h13}};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [SPIMSP_ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, irq_ack = 0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'h0;
  logic sck_in = 0, mosi_in = 0, nss_n_in = 1'b1, p_load = 0, sck_prev = 0;
  logic awready, wready, bvalid, arready, rvalid, irq, sck_out, sck_oe_n;
  logic mosi_out, mosi_oe_n, miso_out, miso_oe_n, miso_in;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata;
  logic [7:0] ctl = 8'h00, p_tx = 8'h00, p_rx, rd, got;
  int p_edges, half, n;
  int fails = 0, n_tests = 0, cyc = 0, gap = 0, min_gap = 0;

  always #12.5 aclk = ~aclk;

  spimsp_port DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .irq(irq), .irq_ack(irq_ack), .sck_in(sck_in), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
    .mosi_in(mosi_in), .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n), .miso_in(miso_in),
    .miso_out(miso_out), .miso_oe_n(miso_oe_n), .nss_n_in(nss_n_in));

  spimsp_slave_model u_slave (.sck(sck_out), .mosi(mosi_out), .miso(miso_in),
    .clock_polarity_bit(ctl[SPIMSP_CTL_CLOCK_POLARITY_BIT]), .clock_phase_bit(ctl[SPIMSP_CTL_CLOCK_PHASE_BIT]),
    .lsb_first(ctl[SPIMSP_CTL_LSB_FIRST]), .tx_byte(p_tx), .load(p_load), .rx_byte(p_rx),
    .n_edges(p_edges));

  // shortest sck half period seen since the partner was loaded
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    sck_prev <= sck_out;
    gap <= (sck_out !== sck_prev) ? 1 : gap + 1;
    if (p_load) begin
      min_gap <= 9999;
    end else if (sck_out !== sck_prev && gap < min_gap) begin
      min_gap <= gap;
    end
    if (cyc == 40000) begin
      fails = fails + 1;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("tests=%0d mismatches=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] val, input logic [31:0] exp);
    n_tests++;
    if (val !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, val, exp);
    end
  endtask : check

  // each bus task is entered just after a rising edge and leaves one edge after release
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] s = 4'h1);
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    resp = bresp;
    bready <= 0;
    @(posedge aclk);
  endtask : wr

  task automatic rd_reg(input logic [7:0] idx);
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    rd = rdata[7:0];
    resp = rresp;
    rready <= 0;
    @(posedge aclk);
  endtask : rd_reg

  // polling arms the flag clear once the flag is seen
  task automatic wait_done();
    n = 0;
    do begin
      rd_reg(SPIMSP_IDX_STATUS);
      n++;
    end while (rd[SPIMSP_STA_TRANSFER_COMPLETE] !== 1'b1 && n < 1000);
  endtask : wait_done

  task automatic load_partner(input logic [7:0] b);
    p_tx <= b;
    p_load <= 1;
    @(posedge aclk);
    p_load <= 0;
  endtask : load_partner

  // bench as external master, mode 0, msb first; nb below 8 aborts the byte
  task automatic sbyte(input logic [7:0] m, input int nb, output logic [7:0] s);
    nss_n_in <= 0;
    repeat (8) @(posedge aclk);
    for (int k = 7; k > 7 - nb; k--) begin
      mosi_in <= m[k];
      repeat (8) @(posedge aclk);
      s[k] = miso_out;
      sck_in <= 1;
      repeat (8) @(posedge aclk);
      sck_in <= 0;
    end
    repeat (8) @(posedge aclk);
    mosi_in <= ~m[8 - nb];
    nss_n_in <= 1;
    repeat (8) @(posedge aclk);
  endtask : sbyte

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd_reg(SPIMSP_IDX_CONTROL);
    check(rd, SPIMSP_CTL_RESET);
    rd_reg(SPIMSP_IDX_PIN_CTRL);
    check(rd, 8'h00);
    check({sck_oe_n, mosi_oe_n, miso_oe_n}, 3'b111);
    wr(SPIMSP_IDX_CONTROL, 8'hFF, 4'h0);
    rd_reg(SPIMSP_IDX_CONTROL);
    check(rd, 8'h00);
    wr(8'h00, 8'h12);
    check(resp, SPIMSP_RESP_SLVERR);
    rd_reg(8'h00);
    check(resp, SPIMSP_RESP_SLVERR);
    $display("reset and map test done");
    // select held high by the bench in master mode
    for (int i = 0; i < 8; i++) begin
      ctl = rows[i].ctl;
      half = 1 << (2 * ctl[1:0] + !rows[i].dbl);
      wr(SPIMSP_IDX_CONTROL, ctl);
      wr(SPIMSP_IDX_STATUS, {7'h0, rows[i].dbl});
      load_partner(rows[i].ptx);
      wr(SPIMSP_IDX_DATA, rows[i].tx);
      wait_done();
      check(irq, ctl[SPIMSP_CTL_INT_EN]);
      rd_reg(SPIMSP_IDX_DATA);
      if (half >= 4) check(rd, rows[i].ptx);
      if (half >= 4) check(p_rx, rows[i].tx);
      check(p_edges, 16);
      check(min_gap, half);
      check(sck_out, ctl[SPIMSP_CTL_CLOCK_POLARITY_BIT]);
      rd_reg(SPIMSP_IDX_STATUS);
      check(rd[SPIMSP_STA_TRANSFER_COMPLETE], 1'b0);
      $display("row %0d done", i);
    end
    ctl = 8'hD5;
    wr(SPIMSP_IDX_CONTROL, ctl);
    wr(SPIMSP_IDX_STATUS, 8'h00);
    load_partner(8'h3C);
    wr(SPIMSP_IDX_DATA, 8'hA5);
    wr(SPIMSP_IDX_DATA, 8'h5A);
    wait_done();
    check(rd[SPIMSP_STA_WRITE_COLLISION], 1'b1);
    rd_reg(SPIMSP_IDX_DATA);
    check(rd, 8'h3C);
    check(p_rx, 8'hA5);
    rd_reg(SPIMSP_IDX_STATUS);
    check(rd[SPIMSP_STA_WRITE_COLLISION], 1'b0);
    load_partner(8'h00);
    wr(SPIMSP_IDX_DATA, 8'h81);
    for (n = 0; n < 400 && irq !== 1'b1; n++) @(posedge aclk);
    check(irq, 1'b1);
    irq_ack <= 1;
    @(posedge aclk);
    irq_ack <= 0;
    repeat (3) @(posedge aclk);
    check(irq, 1'b0);
    rd_reg(SPIMSP_IDX_STATUS);
    check(rd[SPIMSP_STA_TRANSFER_COMPLETE], 1'b0);
    $display("collision and vector test done");
    nss_n_in <= 0;
    repeat (8) @(posedge aclk);
    check(sck_oe_n, 1'b1);
    nss_n_in <= 1;
    rd_reg(SPIMSP_IDX_STATUS);
    check({rd[SPIMSP_STA_TRANSFER_COMPLETE], rd[SPIMSP_STA_MODE_FAULT]}, 2'b11);
    rd_reg(SPIMSP_IDX_CONTROL);
    check(rd[SPIMSP_CTL_MASTER], 1'b0);
    rd_reg(SPIMSP_IDX_PIN_CTRL);
    check(rd, 8'h00);
    rd_reg(SPIMSP_IDX_STATUS);
    ctl = 8'h00;
    wr(SPIMSP_IDX_CONTROL, ctl);
    rd_reg(SPIMSP_IDX_STATUS);
    check(rd[SPIMSP_STA_MODE_FAULT], 1'b0);
    $display("mode fault test done");
    wr(SPIMSP_IDX_CONTROL, 8'h80);
    check({sck_oe_n, mosi_oe_n, miso_oe_n}, 3'b111);
    wr(SPIMSP_IDX_DATA, 8'hC3);
    sbyte(8'h96, 3, got);
    rd_reg(SPIMSP_IDX_STATUS);
    check(rd[SPIMSP_STA_TRANSFER_COMPLETE], 1'b0);
    sbyte(8'h96, 8, got);
    check(got, 8'hC3);
    wait_done();
    check(irq, 1'b0);
    rd_reg(SPIMSP_IDX_DATA);
    check(rd, 8'h96);
    $display("slave test done");
    report_and_stop();
  end
endmodule : tb_top
